/* File: hw/podc_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Global and bridge passive enables set: output Hi-Z, side bits steer switches.
// - Bridge passive enable clear: switches open, output follows side bits.
// - Passive, low side only: pull-down switch closed, pull-up open.
// - Passive, high side only: pull-up switch closed, pull-down open.
// - Passive with equal side bits: both switches open, output Hi-Z.
// - Global enable arms detection on every passive bridge with exactly one side bit set.
// - Clearing bridge passive enable returns bridge to normal driving.
// - Detection sets chip open-load flag, channel flag, pulls fault low.
// - Open-load flag holds until clear-faults command.
// - Active-diagnosis disable bits do not block passive sequence.
// - Other faults present (not overcurrent/open-load) block sequence start.
// - Report control bit gates fault pin for passive results too.
// - Keep-driving-on-open-load setting ignored during passive diagnosis.
// - Strong-pull bit selects smaller test resistance for supply loads.
// - Tested outputs stay off; diagnosis runs before driving.
// - Recovery needs only clear-faults in a cycle with no detection.
module podc_top #(
	parameter int NB = podc_pkg::NUM_BRIDGES
) (
	input  wire logic          sys_clk_in,
	input  wire logic          rst_in,
	input  wire logic          global_passive_diag_enable_in,
	input  wire logic [NB-1:0] bridge_passive_diag_enable_in,
	input  wire logic [NB-1:0] high_side_enable_in,
	input  wire logic [NB-1:0] low_side_enable_in,
	input  wire logic [NB-1:0] supply_load_strong_pull_in,
	input  wire logic [NB-1:0] active_diag_disable_in,
	input  wire logic          open_load_report_ctrl_in,
	input  wire logic          keep_driving_on_open_load_in,
	input  wire logic          clear_faults_cmd_in,
	input  wire logic          other_fault_in,
	input  wire logic [NB-1:0] high_side_comparator_out_in,
	input  wire logic [NB-1:0] low_side_comparator_out_in,
	output logic      [NB-1:0] high_side_gate_out,
	output logic      [NB-1:0] low_side_gate_out,
	output logic      [NB-1:0] pullup_test_switch_out,
	output logic      [NB-1:0] pulldown_test_switch_out,
	output logic      [NB-1:0] strong_pull_select_out,
	output logic               passive_active_out,
	output logic               open_load_flag_out,
	output logic      [NB-1:0] high_side_open_flag_out,
	output logic      [NB-1:0] low_side_open_flag_out,
	output logic               fault_out_n
);
	podc_pkg::podc_state_t state_q;
	logic                  test_active;
	logic [NB-1:0]         hs_det;
	logic [NB-1:0]         ls_det;
	logic                  any_det;

	// Sequence state; active-diagnosis disable and keep-driving bits
	// deliberately play no part here
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state_q <= podc_pkg::PODC_IDLE;
		end else begin
			case (state_q)
				podc_pkg::PODC_IDLE: begin
					if (global_passive_diag_enable_in && other_fault_in) begin
						state_q <= podc_pkg::PODC_BLOCK;
					end else if (global_passive_diag_enable_in) begin
						state_q <= podc_pkg::PODC_TEST;
					end
				end
				podc_pkg::PODC_TEST: begin
					if (!global_passive_diag_enable_in) begin
						state_q <= podc_pkg::PODC_IDLE;
					end
				end
				// Refused sequence waits for the global enable to drop
				podc_pkg::PODC_BLOCK: begin
					if (!global_passive_diag_enable_in) begin
						state_q <= podc_pkg::PODC_IDLE;
					end
				end
				default: state_q <= podc_pkg::PODC_IDLE;
			endcase
		end
	end

	assign test_active = state_q == podc_pkg::PODC_TEST;

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			passive_active_out     <= 1'h0;
			strong_pull_select_out <= '0;
		end else begin
			passive_active_out     <= test_active;
			strong_pull_select_out <= supply_load_strong_pull_in;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NB; gi++) begin : g_ch
			podc_channel u_ch (
				.sys_clk_in                    (sys_clk_in),
				.rst_in                        (rst_in),
				.test_active_in                (test_active),
				.bridge_passive_diag_enable_in (bridge_passive_diag_enable_in[gi]),
				.high_side_enable_in           (high_side_enable_in[gi]),
				.low_side_enable_in            (low_side_enable_in[gi]),
				.high_side_comparator_out_in   (high_side_comparator_out_in[gi]),
				.low_side_comparator_out_in    (low_side_comparator_out_in[gi]),
				.high_side_gate_out            (high_side_gate_out[gi]),
				.low_side_gate_out             (low_side_gate_out[gi]),
				.pullup_test_switch_out        (pullup_test_switch_out[gi]),
				.pulldown_test_switch_out      (pulldown_test_switch_out[gi]),
				.high_side_detect_out          (hs_det[gi]),
				.low_side_detect_out           (ls_det[gi])
			);
		end
	endgenerate

	assign any_det = |{hs_det, ls_det};

	// Sticky flags: a detection in the clear cycle wins over the clear
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			open_load_flag_out      <= podc_pkg::RST_FLAG;
			high_side_open_flag_out <= '0;
			low_side_open_flag_out  <= '0;
		end else if (clear_faults_cmd_in) begin
			open_load_flag_out      <= any_det;
			high_side_open_flag_out <= hs_det;
			low_side_open_flag_out  <= ls_det;
		end else begin
			open_load_flag_out      <= open_load_flag_out | any_det;
			high_side_open_flag_out <= high_side_open_flag_out | hs_det;
			low_side_open_flag_out  <= low_side_open_flag_out | ls_det;
		end
	end

	// Report bit set keeps the fault pin quiet; status flags still latch
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			fault_out_n <= podc_pkg::RST_FAULT_N;
		end else if (open_load_report_ctrl_in) begin
			fault_out_n <= 1'h1;
		end else if (clear_faults_cmd_in) begin
			fault_out_n <= ~any_det;
		end else begin
			fault_out_n <= ~(any_det | ~fault_out_n);
		end
	end
endmodule
`default_nettype wire

/* File: hw/podc_pkg.sv */
package podc_pkg;
	// Number of half-bridges served by default
	localparam int NUM_BRIDGES   = 12;
	// Comparator results must stand this many cycles to count as a detection
	localparam int DEGLITCH_CYC  = 4;
	localparam int DEGLITCH_W    = 3;
	// Reset values of control outputs
	localparam logic RST_FAULT_N = 1'h1;
	localparam logic RST_SWITCH  = 1'h0;
	localparam logic RST_FLAG    = 1'h0;

	typedef enum logic [1:0] {
		PODC_IDLE  = 2'h0,
		PODC_TEST  = 2'h1,
		PODC_BLOCK = 2'h3
	} podc_state_t;
endpackage

/* File: hw/podc_channel.sv */
`timescale 1ns/1ps
`default_nettype none
// One half-bridge: switch steering, output gating and comparator deglitch
module podc_channel (
	input  wire logic sys_clk_in,
	input  wire logic rst_in,
	input  wire logic test_active_in,
	input  wire logic bridge_passive_diag_enable_in,
	input  wire logic high_side_enable_in,
	input  wire logic low_side_enable_in,
	input  wire logic high_side_comparator_out_in,
	input  wire logic low_side_comparator_out_in,
	output logic      high_side_gate_out,
	output logic      low_side_gate_out,
	output logic      pullup_test_switch_out,
	output logic      pulldown_test_switch_out,
	output logic      high_side_detect_out,
	output logic      low_side_detect_out
);
	logic                             passive;
	logic                             pu_sel;
	logic                             pd_sel;
	logic [podc_pkg::DEGLITCH_W-1:0]  hs_cnt_q;
	logic [podc_pkg::DEGLITCH_W-1:0]  ls_cnt_q;

	assign passive = bridge_passive_diag_enable_in;
	// Equal side enables select neither switch
	assign pu_sel = high_side_enable_in & ~low_side_enable_in;
	assign pd_sel = low_side_enable_in & ~high_side_enable_in;

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			high_side_gate_out       <= 1'h0;
			low_side_gate_out        <= 1'h0;
			pullup_test_switch_out   <= podc_pkg::RST_SWITCH;
			pulldown_test_switch_out <= podc_pkg::RST_SWITCH;
		end else begin
			// Passive bridge stays Hi-Z even while the global enable is low
			high_side_gate_out <= ~passive & high_side_enable_in;
			low_side_gate_out  <= ~passive & low_side_enable_in;
			pullup_test_switch_out   <= passive & test_active_in & pu_sel;
			pulldown_test_switch_out <= passive & test_active_in & pd_sel;
		end
	end

	// Counter saturates; filters comparator chatter while switches settle
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || !(passive && test_active_in && pu_sel)) begin
			hs_cnt_q <= '0;
		end else if (high_side_comparator_out_in &&
			hs_cnt_q != podc_pkg::DEGLITCH_W'(podc_pkg::DEGLITCH_CYC)) begin
			hs_cnt_q <= hs_cnt_q + 1'h1;
		end else if (!high_side_comparator_out_in) begin
			hs_cnt_q <= '0;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in || !(passive && test_active_in && pd_sel)) begin
			ls_cnt_q <= '0;
		end else if (low_side_comparator_out_in &&
			ls_cnt_q != podc_pkg::DEGLITCH_W'(podc_pkg::DEGLITCH_CYC)) begin
			ls_cnt_q <= ls_cnt_q + 1'h1;
		end else if (!low_side_comparator_out_in) begin
			ls_cnt_q <= '0;
		end
	end

	// Invalid combinations never arm a counter, so they never detect
	assign high_side_detect_out =
		hs_cnt_q == podc_pkg::DEGLITCH_W'(podc_pkg::DEGLITCH_CYC);
	assign low_side_detect_out =
		ls_cnt_q == podc_pkg::DEGLITCH_W'(podc_pkg::DEGLITCH_CYC);
endmodule
`default_nettype wire

/* File: dv/podc_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module podc_checker #(parameter int NB = 2) (
	input wire logic          sys_clk_in,
	input wire logic          rst_in,
	input wire logic [NB-1:0] bridge_passive_diag_enable_in,
	input wire logic [NB-1:0] high_side_enable_in,
	input wire logic [NB-1:0] low_side_enable_in,
	input wire logic          clear_faults_cmd_in,
	input wire logic          open_load_report_ctrl_in,
	input wire logic          other_fault_in,
	input wire logic [NB-1:0] high_side_gate_out,
	input wire logic [NB-1:0] low_side_gate_out,
	input wire logic [NB-1:0] pullup_test_switch_out,
	input wire logic [NB-1:0] pulldown_test_switch_out,
	input wire logic          passive_active_out,
	input wire logic          open_load_flag_out,
	input wire logic [NB-1:0] high_side_open_flag_out,
	input wire logic [NB-1:0] low_side_open_flag_out,
	input wire logic          fault_out_n
);
	wire [NB-1:0] pe = bridge_passive_diag_enable_in;
	wire [NB-1:0] hs = high_side_enable_in;
	wire [NB-1:0] ls = low_side_enable_in;
	wire [NB-1:0] pu_ok = pe & hs & ~ls;
	wire [NB-1:0] pd_ok = pe & ls & ~hs;
	wire [NB-1:0] same  = ~(hs ^ ls);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	chk_hs_gate: assert property (1 |=>
		high_side_gate_out == ($past(hs) & ~$past(pe)))
		else $error("high gate wrong");
	chk_ls_gate: assert property (1 |=>
		low_side_gate_out == ($past(ls) & ~$past(pe)))
		else $error("low gate wrong");
	chk_sw_excl: assert property (
		((pullup_test_switch_out | pulldown_test_switch_out) &
		$past(same)) == '0)
		else $error("switch closed with equal side bits");
	chk_pu_sel: assert property (
		(pullup_test_switch_out & ~$past(pu_ok)) == '0)
		else $error("pull-up closed wrongly");
	chk_pd_sel: assert property (
		(pulldown_test_switch_out & ~$past(pd_ok)) == '0)
		else $error("pull-down closed wrongly");
	chk_flag_hold: assert property (
		$fell(open_load_flag_out) |-> $past(clear_faults_cmd_in))
		else $error("flag dropped without clear");
	chk_flag_sum: assert property (
		open_load_flag_out ==
		|{high_side_open_flag_out, low_side_open_flag_out})
		else $error("chip flag mismatch");
	chk_fault_rep: assert property (
		$rose(open_load_flag_out) |->
		fault_out_n == $past(open_load_report_ctrl_in))
		else $error("fault pin wrong");
	chk_block_seq: assert property (
		$rose(passive_active_out) |-> !$past(other_fault_in, 2))
		else $error("sequence started under fault");
	cover property ($rose(open_load_flag_out));
	cover property ($rose(passive_active_out));
	cover property (pulldown_test_switch_out != '0);
	cover property ($rose(|low_side_open_flag_out));
endmodule
bind podc_top podc_checker #(.NB(NB)) u_chk (.sys_clk_in, .rst_in,
	.bridge_passive_diag_enable_in, .high_side_enable_in,
	.low_side_enable_in, .clear_faults_cmd_in, .open_load_report_ctrl_in,
	.other_fault_in, .high_side_gate_out, .low_side_gate_out,
	.pullup_test_switch_out, .pulldown_test_switch_out, .passive_active_out,
	.open_load_flag_out, .high_side_open_flag_out, .low_side_open_flag_out,
	.fault_out_n);
`default_nettype wire

/* File: dv/tb_podc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_podc_top;
	localparam int NB = 2;
	logic          clk = 1'h0, rst = 1'h1, ge = 1'h0, rc = 1'h0;
	logic          kd = 1'h0, cf = 1'h0, ofl = 1'h0;
	logic [NB-1:0] pe = 2'h0, hs = 2'h0, ls = 2'h0, sp = 2'h0;
	logic [NB-1:0] ad = 2'h0, hc = 2'h0, lc = 2'h0;
	logic [NB-1:0] hg, lg, pu, pd, ss, hf, lf;
	logic          pa, olf, fn;
	int            num_errors = 0;
	int            tests_run = 0;
	podc_top #(.NB(NB)) dut (.sys_clk_in(clk), .rst_in(rst),
		.global_passive_diag_enable_in(ge),
		.bridge_passive_diag_enable_in(pe), .high_side_enable_in(hs),
		.low_side_enable_in(ls), .supply_load_strong_pull_in(sp),
		.active_diag_disable_in(ad), .open_load_report_ctrl_in(rc),
		.keep_driving_on_open_load_in(kd), .clear_faults_cmd_in(cf),
		.other_fault_in(ofl), .high_side_comparator_out_in(hc),
		.low_side_comparator_out_in(lc), .high_side_gate_out(hg),
		.low_side_gate_out(lg), .pullup_test_switch_out(pu),
		.pulldown_test_switch_out(pd), .strong_pull_select_out(ss),
		.passive_active_out(pa), .open_load_flag_out(olf),
		.high_side_open_flag_out(hf), .low_side_open_flag_out(lf),
		.fault_out_n(fn));
	always #4 clk = ~clk;
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic t_drive();
		@(posedge clk);
		hs <= 2'h1;
		ls <= 2'h2;
		sp <= 2'h2;
		cyc(2);
		chk({hg, lg}, 4'h6);
		chk(ss, 2'h2);
		@(posedge clk);
		pe <= 2'h1;
		cyc(2);
		chk({hg, lg}, 4'h2);
		@(posedge clk);
		pe <= 2'h0;
		cyc(2);
		chk({hg, lg}, 4'h6);
	endtask
	// Bridge enables first, side bits next, global enable last
	task automatic t_sw(input logic [1:0] h, l, eu, ed);
		@(posedge clk);
		pe <= 2'h3;
		@(posedge clk);
		hs <= h;
		ls <= l;
		@(posedge clk);
		ge <= 1'h1;
		cyc(4);
		chk({pa, pu, pd, hg | lg}, {1'h1, eu, ed, 2'h0});
		@(posedge clk);
		ge <= 1'h0;
		cyc(4);
		chk({pu, pd}, 4'h0);
	endtask
	task automatic t_det(input logic rep);
		@(posedge clk);
		rc <= rep;
		ad <= 2'h3;
		kd <= 1'h1;
		hs <= 2'h3;
		ls <= 2'h2;
		hc <= 2'h3;
		lc <= 2'h3;
		@(posedge clk);
		ge <= 1'h1;
		cyc(12);
		chk({olf, hf, lf, fn}, {1'h1, 2'h1, 2'h0, rep});
		@(posedge clk);
		ge <= 1'h0;
		hc <= 2'h0;
		lc <= 2'h0;
		cyc(4);
		chk({olf, fn}, {1'h1, rep});
		@(posedge clk);
		cf <= 1'h1;
		@(posedge clk);
		cf <= 1'h0;
		cyc(2);
		chk({olf, hf, fn}, 4'h1);
	endtask
	// Single-ended loads; a clear while the fault stands must not recover
	task automatic t_load(input logic [1:0] h, l, s, c, eh, el);
		@(posedge clk);
		rc <= 1'h0;
		hs <= h;
		ls <= l;
		sp <= s;
		hc <= c;
		lc <= c;
		@(posedge clk);
		ge <= 1'h1;
		cyc(8);
		chk({ss, hf, lf, olf, fn}, {s, eh, el, 2'h2});
		@(posedge clk);
		cf <= 1'h1;
		@(posedge clk);
		cf <= 1'h0;
		cyc(2);
		chk({hf, lf, olf, fn}, {eh, el, 2'h2});
		@(posedge clk);
		ge <= 1'h0;
		hc <= 2'h0;
		lc <= 2'h0;
		@(posedge clk);
		cf <= 1'h1;
		@(posedge clk);
		cf <= 1'h0;
		cyc(2);
		chk({hf, lf, olf, fn}, 6'h1);
	endtask
	task automatic t_block();
		@(posedge clk);
		ofl <= 1'h1;
		hs <= 2'h1;
		ls <= 2'h0;
		hc <= 2'h1;
		cyc(2);
		@(posedge clk);
		ge <= 1'h1;
		cyc(10);
		chk({pa, pu, olf}, 4'h0);
		@(posedge clk);
		ge <= 1'h0;
		ofl <= 1'h0;
		hc <= 2'h0;
		cyc(3);
	endtask
	task automatic wrap_up();
		if (num_errors == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		t_drive();
		t_sw(2'h1, 2'h2, 2'h1, 2'h2);
		t_sw(2'h3, 2'h3, 2'h0, 2'h0);
		t_sw(2'h0, 2'h0, 2'h0, 2'h0);
		t_det(1'h0);
		t_det(1'h1);
		t_load(2'h3, 2'h0, 2'h0, 2'h2, 2'h2, 2'h0);
		t_load(2'h0, 2'h3, 2'h3, 2'h1, 2'h0, 2'h1);
		t_block();
		wrap_up();
	end
	initial begin
		#20000;
		num_errors++;
		wrap_up();
	end
endmodule
`default_nettype wire
